// ### common/sicr_pkg.sv
// Constants for the IF reference, IF control and RF phase resync logic.
// Assumes a 24-bit serial word whose three lowest bits carry the address.
package sicr_pkg;

  // Serial word shape
  localparam int unsigned SICR_WORD_W = 24;
  localparam int unsigned SICR_ADDR_W = 3;
  localparam int unsigned SICR_ADDR_LSB = 0;
  localparam int unsigned SICR_ADDR_MSB = 2;

  // Latch addresses
  localparam logic [2:0] SICR_ADDR_RF_FREQ_A = 3'h0;
  localparam logic [2:0] SICR_ADDR_RF_FREQ_B = 3'h1;
  localparam logic [2:0] SICR_ADDR_RF_CTRL = 3'h2;
  localparam logic [2:0] SICR_ADDR_MASTER = 3'h3;
  localparam logic [2:0] SICR_ADDR_IF_N = 3'h4;
  localparam logic [2:0] SICR_ADDR_IF_REF_DIV = 3'h5;
  localparam logic [2:0] SICR_ADDR_IF_CTRL = 3'h6;

  // IF reference divider register fields
  localparam int unsigned SICR_RDIV_W = 15;
  localparam int unsigned SICR_RDIV_LSB = 3;
  localparam int unsigned SICR_RDIV_MSB = 17;
  localparam int unsigned SICR_DOUBLER_BIT = 18;

  // IF control register fields
  localparam int unsigned SICR_CTL_CNT_RESET = 3;
  localparam int unsigned SICR_CTL_CP_3STATE = 4;
  localparam int unsigned SICR_CTL_POWERDOWN = 5;
  localparam int unsigned SICR_CTL_PD_POLARITY = 7;
  localparam int unsigned SICR_CTL_CP_CUR_LSB = 8;
  localparam int unsigned SICR_CTL_CP_CUR_MSB = 10;
  localparam int unsigned SICR_CTL_CP_CUR_W = 3;
  localparam int unsigned SICR_CTL_RESYNC_B11 = 11;
  localparam int unsigned SICR_CTL_TEST_LSB = 12;
  localparam int unsigned SICR_CTL_TEST_MSB = 13;
  localparam int unsigned SICR_CTL_TEST_W = 2;
  localparam int unsigned SICR_CTL_RESYNC_B14 = 14;
  localparam int unsigned SICR_CTL_RESYNC_B15 = 15;

  // Reset values
  localparam logic [23:0] SICR_WORD_RESET = 24'h000000;
  localparam logic [14:0] SICR_CNT_ZERO = 15'h0000;
  localparam logic [14:0] SICR_CNT_ONE = 15'h0001;

endpackage : sicr_pkg

// ### logic/sicr_sync.sv
// Three-stage pin synchroniser with a two-stage agreement filter.
// Assumes asynchronous pin inputs; one clock domain on clk_i.
`timescale 1ns/100ps
`default_nettype none
module sicr_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins in, filtered levels out
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  genvar gi;

  // One chain per pin; stage one feeds only stage two
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic stage1_r;
      logic stage2_r;
      logic stage3_r;
      logic level_r;

      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          stage1_r <= 1'b0;
          stage2_r <= 1'b0;
          stage3_r <= 1'b0;
          level_r <= 1'b0;
        end
        else
        begin
          stage1_r <= pin_i[gi];
          stage2_r <= stage1_r;
          stage3_r <= stage2_r;
          // A change counts only once two late stages agree
          if (stage2_r == stage3_r)
          begin
            level_r <= stage3_r;
          end
        end
      end

      assign level_o[gi] = level_r;
    end
  endgenerate

endmodule : sicr_sync
`default_nettype wire

// ### logic/sicr_top.sv
// IF reference path, IF control word and RF phase resync for a dual synthesizer.
// Assumes a host drives the three-wire port; reference input is a slow pin.
//
// Notes on behaviour
// - Doubler bit 0 passes reference straight on; 1 doubles it before divider.
// - Fifteen-bit IF reference divider divides by any ratio 1 to 32767.
// - Latched word with address bits 110 loads the IF control register.
// - IF control bit 3 set holds IF counters in reset.
// - Charge pump three-state bit set makes IF charge pump high impedance.
// - IF control bit 5 powers IF down; contents retained meanwhile.
// - IF power-down loads counters, three-states pump, resets lock detect.
// - Serial shift register keeps accepting and latching words in power-down.
// - IF control bit 7 selects IF phase detector polarity.
// - IF control bits 10 to 8 select IF charge pump current.
// - Phase resync enabled only when control bits 15, 14, 11 are all one.
// - With resync enabled, each RF frequency register write triggers resync.
// - Resync fires after divider field count of reference input cycles.
// - IF side stays down until IF control, IF R, IF N, master written.
// - RF side stays down until master, RF control, both frequency words written.
// - Twenty-four bits shift on rising clock; latch strobe rise transfers word.
`timescale 1ns/100ps
`default_nettype none
module sicr_top
  import sicr_pkg::*;
#(
  parameter int unsigned WORD_W = SICR_WORD_W,
  parameter int unsigned RDIV_W = SICR_RDIV_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Three-wire serial port pins
  input wire logic serial_clock_i,
  input wire logic serial_input_line_i,
  input wire logic latch_strobe_i,
  // Reference input pin
  input wire logic reference_input_i,
  // IF phase frequency detector reference
  output logic if_pfd_ref_tick_o,
  // IF control outputs
  output logic if_counter_reset_o,
  output logic if_charge_pump_tristate_o,
  output logic if_powerdown_o,
  output logic if_lock_detect_reset_o,
  output logic if_pd_polarity_o,
  output logic [SICR_CTL_CP_CUR_W-1:0] if_charge_pump_current_o,
  output logic [SICR_CTL_TEST_W-1:0] if_test_mode_o,
  // Power-up tracking
  output logic if_side_awake_o,
  output logic rf_side_awake_o,
  // RF phase resync
  output logic resync_enable_o,
  output logic resync_pending_o,
  output logic resync_fire_o
);

  // Filtered pin levels
  logic [3:0] pins_sync;
  logic sclk_lvl;
  logic serial_input_line_lvl;
  logic latch_lvl;
  logic ref_lvl;

  // Edge history
  logic sclk_prev_r;
  logic latch_prev_r;
  logic ref_prev_r;
  logic sclk_rise;
  logic latch_rise;
  logic ref_rise;
  logic ref_fall;

  // Serial shift register and latches
  logic [WORD_W-1:0] shift_r;
  logic [SICR_ADDR_W-1:0] word_addr;
  logic [WORD_W-1:0] if_ref_div_r;
  logic [WORD_W-1:0] if_ctrl_r;

  // Written flags for power-up tracking
  logic wr_rf_a_r;
  logic wr_rf_b_r;
  logic wr_rf_ctrl_r;
  logic wr_master_r;
  logic wr_if_n_r;
  logic wr_if_ref_r;
  logic wr_if_ctrl_r;
  logic if_awake;
  logic rf_awake;

  // IF reference divider
  logic [RDIV_W-1:0] div_ratio;
  logic [RDIV_W-1:0] div_cnt_r;
  logic [RDIV_W-1:0] div_cnt_nxt;
  logic div_event;
  logic div_hold;
  logic div_wrap;

  // Resync timing
  logic resync_en;
  logic rf_freq_write;
  logic [RDIV_W-1:0] rs_cnt_r;
  logic [RDIV_W-1:0] rs_cnt_nxt;
  logic rs_pending_r;
  logic rs_fire_r;

  // Derived IF control state
  logic pd_active;
  logic tristate_nxt;
  logic cnt_reset_nxt;

  // All four pins pass the agreement synchroniser
  sicr_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({reference_input_i, latch_strobe_i, serial_input_line_i, serial_clock_i}),
    .level_o(pins_sync)
  );

  assign sclk_lvl = pins_sync[0];
  assign serial_input_line_lvl = pins_sync[1];
  assign latch_lvl = pins_sync[2];
  assign ref_lvl = pins_sync[3];

  // Edge detectors work on filtered levels only
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_prev_r <= 1'b0;
      latch_prev_r <= 1'b0;
      ref_prev_r <= 1'b0;
    end
    else
    begin
      sclk_prev_r <= sclk_lvl;
      latch_prev_r <= latch_lvl;
      ref_prev_r <= ref_lvl;
    end
  end

  assign sclk_rise = sclk_lvl & ~sclk_prev_r;
  assign latch_rise = latch_lvl & ~latch_prev_r;
  assign ref_rise = ref_lvl & ~ref_prev_r;
  assign ref_fall = ~ref_lvl & ref_prev_r;
  assign word_addr = shift_r[SICR_ADDR_MSB:SICR_ADDR_LSB];

  // Shift register never gated by power-down, so words land at any time
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shift_r <= SICR_WORD_RESET;
    end
    else if (sclk_rise)
    begin
      shift_r <= {shift_r[WORD_W-2:0], serial_input_line_lvl};
    end
  end

  // Address decode on latch strobe rise; power-down bits do not clear these
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      if_ref_div_r <= SICR_WORD_RESET;
      if_ctrl_r <= SICR_WORD_RESET;
    end
    else if (latch_rise)
    begin
      if (word_addr == SICR_ADDR_IF_REF_DIV)
      begin
        if_ref_div_r <= shift_r;
      end
      if (word_addr == SICR_ADDR_IF_CTRL)
      begin
        if_ctrl_r <= shift_r;
      end
    end
  end

  // Sticky written flags; only a reset clears them
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_rf_a_r <= 1'b0;
      wr_rf_b_r <= 1'b0;
      wr_rf_ctrl_r <= 1'b0;
      wr_master_r <= 1'b0;
      wr_if_n_r <= 1'b0;
      wr_if_ref_r <= 1'b0;
      wr_if_ctrl_r <= 1'b0;
    end
    else if (latch_rise)
    begin
      wr_rf_a_r <= wr_rf_a_r | (word_addr == SICR_ADDR_RF_FREQ_A);
      wr_rf_b_r <= wr_rf_b_r | (word_addr == SICR_ADDR_RF_FREQ_B);
      wr_rf_ctrl_r <= wr_rf_ctrl_r | (word_addr == SICR_ADDR_RF_CTRL);
      wr_master_r <= wr_master_r | (word_addr == SICR_ADDR_MASTER);
      wr_if_n_r <= wr_if_n_r | (word_addr == SICR_ADDR_IF_N);
      wr_if_ref_r <= wr_if_ref_r | (word_addr == SICR_ADDR_IF_REF_DIV);
      wr_if_ctrl_r <= wr_if_ctrl_r | (word_addr == SICR_ADDR_IF_CTRL);
    end
  end

  // Each side wakes only once its full register set has been written
  assign if_awake = wr_if_ctrl_r & wr_if_ref_r & wr_if_n_r & wr_master_r;
  assign rf_awake = wr_master_r & wr_rf_ctrl_r & wr_rf_a_r & wr_rf_b_r;

  // Not yet awake counts as powered down for the IF section
  assign pd_active = if_ctrl_r[SICR_CTL_POWERDOWN] | ~if_awake;
  assign tristate_nxt = if_ctrl_r[SICR_CTL_CP_3STATE] | pd_active;
  assign cnt_reset_nxt = if_ctrl_r[SICR_CTL_CNT_RESET] | pd_active;

  // Doubler counts both reference edges, otherwise rising edges only
  assign div_event = if_ref_div_r[SICR_DOUBLER_BIT] ? (ref_rise | ref_fall) : ref_rise;
  assign div_ratio = if_ref_div_r[SICR_RDIV_MSB:SICR_RDIV_LSB];
  assign div_hold = cnt_reset_nxt;
  // A ratio of zero is not legal; it behaves as divide by one
  assign div_wrap = (div_cnt_r >= (div_ratio - SICR_CNT_ONE)) | (div_ratio == SICR_CNT_ZERO);

  // Divider next count
  always_comb
  begin
    div_cnt_nxt = div_cnt_r;
    if (div_hold)
    begin
      div_cnt_nxt = SICR_CNT_ZERO;
    end
    else if (div_event)
    begin
      if (div_wrap)
      begin
        div_cnt_nxt = SICR_CNT_ZERO;
      end
      else
      begin
        div_cnt_nxt = div_cnt_r + SICR_CNT_ONE;
      end
    end
  end

  // Divider state and its one-cycle reference tick
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      div_cnt_r <= SICR_CNT_ZERO;
      if_pfd_ref_tick_o <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_cnt_nxt;
      if_pfd_ref_tick_o <= ~div_hold & div_event & div_wrap;
    end
  end

  // Resync gate and trigger
  assign resync_en = if_ctrl_r[SICR_CTL_RESYNC_B15] & if_ctrl_r[SICR_CTL_RESYNC_B14]
    & if_ctrl_r[SICR_CTL_RESYNC_B11];
  assign rf_freq_write = latch_rise & resync_en
    & ((word_addr == SICR_ADDR_RF_FREQ_A) | (word_addr == SICR_ADDR_RF_FREQ_B));

  // Delay counts raw reference cycles, unaffected by the doubler
  always_comb
  begin
    rs_cnt_nxt = rs_cnt_r;
    if (rf_freq_write)
    begin
      rs_cnt_nxt = SICR_CNT_ZERO;
    end
    else if (rs_pending_r & ref_rise)
    begin
      rs_cnt_nxt = rs_cnt_r + SICR_CNT_ONE;
    end
  end

  // Pending delay; a fresh write wins over a fire in the same cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rs_cnt_r <= SICR_CNT_ZERO;
      rs_pending_r <= 1'b0;
      rs_fire_r <= 1'b0;
    end
    else
    begin
      rs_cnt_r <= rs_cnt_nxt;
      rs_fire_r <= 1'b0;
      if (rf_freq_write)
      begin
        rs_pending_r <= 1'b1;
      end
      else if (rs_pending_r & ~resync_en)
      begin
        rs_pending_r <= 1'b0; // Disabling resync drops a pending delay
      end
      else if (rs_pending_r & ref_rise & (rs_cnt_nxt >= div_ratio))
      begin
        rs_pending_r <= 1'b0;
        rs_fire_r <= 1'b1;
      end
    end
  end

  // Registered copies of every IF control output
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      if_counter_reset_o <= 1'b1;
      if_charge_pump_tristate_o <= 1'b1;
      if_powerdown_o <= 1'b1;
      if_lock_detect_reset_o <= 1'b1;
      if_pd_polarity_o <= 1'b0;
      if_charge_pump_current_o <= 3'h0;
      if_test_mode_o <= 2'h0;
    end
    else
    begin
      if_counter_reset_o <= cnt_reset_nxt;
      if_charge_pump_tristate_o <= tristate_nxt;
      if_powerdown_o <= pd_active;
      if_lock_detect_reset_o <= pd_active;
      if_pd_polarity_o <= if_ctrl_r[SICR_CTL_PD_POLARITY];
      if_charge_pump_current_o <= if_ctrl_r[SICR_CTL_CP_CUR_MSB:SICR_CTL_CP_CUR_LSB];
      if_test_mode_o <= if_ctrl_r[SICR_CTL_TEST_MSB:SICR_CTL_TEST_LSB];
    end
  end

  // Registered status outputs
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      if_side_awake_o <= 1'b0;
      rf_side_awake_o <= 1'b0;
      resync_enable_o <= 1'b0;
      resync_pending_o <= 1'b0;
      resync_fire_o <= 1'b0;
    end
    else
    begin
      if_side_awake_o <= if_awake;
      rf_side_awake_o <= rf_awake;
      resync_enable_o <= resync_en;
      resync_pending_o <= rs_pending_r;
      resync_fire_o <= rs_fire_r;
    end
  end

endmodule : sicr_top
`default_nettype wire

// ### bench/sicr_asserts.sv
// Port checker for the IF control and resync block.
// Assumes a bind onto sicr_top, one clock domain on clk_i.
`timescale 1ns/100ps
`default_nettype none
module sicr_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched outputs
  input wire logic if_pfd_ref_tick_o,
  input wire logic if_counter_reset_o,
  input wire logic if_charge_pump_tristate_o,
  input wire logic if_powerdown_o,
  input wire logic if_lock_detect_reset_o,
  input wire logic if_side_awake_o,
  input wire logic rf_side_awake_o,
  input wire logic resync_enable_o,
  input wire logic resync_pending_o,
  input wire logic resync_fire_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Power-down side effects
  property p_lock_pd;
    if_lock_detect_reset_o == if_powerdown_o;
  endproperty
  a_lock_pd: assert property (p_lock_pd) else $error("lock reset differs");
  property p_pd_forces;
    if_powerdown_o |-> if_counter_reset_o && if_charge_pump_tristate_o;
  endproperty
  a_pd_forces: assert property (p_pd_forces) else $error("pd not forcing");
  property p_no_tick;
    if_counter_reset_o && $past(if_counter_reset_o) |-> !if_pfd_ref_tick_o;
  endproperty
  a_no_tick: assert property (p_no_tick) else $error("tick while held");
  property p_tick_pulse;
    if_pfd_ref_tick_o |=> !if_pfd_ref_tick_o;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");

  // Wake-up tracking; only reset clears it
  property p_awake_pd;
    !if_side_awake_o |-> if_powerdown_o;
  endproperty
  a_awake_pd: assert property (p_awake_pd) else $error("IF up too early");
  property p_if_sticky;
    if_side_awake_o |=> if_side_awake_o;
  endproperty
  a_if_sticky: assert property (p_if_sticky) else $error("IF awake lost");
  property p_rf_sticky;
    rf_side_awake_o |=> rf_side_awake_o;
  endproperty
  a_rf_sticky: assert property (p_rf_sticky) else $error("RF awake lost");

  // Resync sequencing
  property p_pend_en;
    $rose(resync_pending_o) |-> resync_enable_o;
  endproperty
  a_pend_en: assert property (p_pend_en) else $error("pending unenabled");
  property p_fire;
    resync_fire_o |-> $past(resync_pending_o) ##1 !resync_fire_o;
  endproperty
  a_fire: assert property (p_fire) else $error("bad fire");

  c_tick: cover property (if_pfd_ref_tick_o);
  c_fire: cover property (resync_fire_o);
  c_awake: cover property ($rose(rf_side_awake_o));
endmodule : sicr_asserts
bind sicr_top sicr_asserts chk_u (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .if_pfd_ref_tick_o(if_pfd_ref_tick_o),
  .if_counter_reset_o(if_counter_reset_o),
  .if_charge_pump_tristate_o(if_charge_pump_tristate_o),
  .if_powerdown_o(if_powerdown_o),
  .if_lock_detect_reset_o(if_lock_detect_reset_o),
  .if_side_awake_o(if_side_awake_o),
  .rf_side_awake_o(rf_side_awake_o),
  .resync_enable_o(resync_enable_o),
  .resync_pending_o(resync_pending_o),
  .resync_fire_o(resync_fire_o)
);
`default_nettype wire

// ### bench/sicr_host.sv
// Host model driving the three-wire serial port.
// Assumes the block clock paces it; pins change at falling edges.
`timescale 1ns/100ps
`default_nettype none
module sicr_host (
  // Clock
  input wire logic clk_i,
  // Serial pins
  output logic sclk_o,
  output logic serial_input_line_o,
  output logic latch_o
);
  // Idle pins
  initial
  begin
    sclk_o = 1'b0;
    serial_input_line_o = 1'b0;
    latch_o = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask : hold

  // MSB first; pace is clocks per level, 2 at the least
  task automatic send_word(input logic [23:0] w, input int pace);
    for (int i = 23; i >= 0; i--)
    begin
      serial_input_line_o = w[i];
      hold(pace);
      sclk_o = 1'b1;
      hold(pace);
      sclk_o = 1'b0;
    end
    // Data released: show a stale-free level
    serial_input_line_o = ~w[0];
    hold(pace);
    latch_o = 1'b1;
    hold(6);
    latch_o = 1'b0;
    hold(14);
  endtask : send_word
endmodule : sicr_host
`default_nettype wire

// ### bench/tb_synth_if_control_resync.sv
// Self-checking bench for the IF control and resync block.
// Assumes the host model on the serial pins; reference made here.
`timescale 1ns/100ps
`default_nettype none
module tb_synth_if_control_resync;
  import sicr_pkg::*;
  // Pins and outputs
  logic clk_i, rst_i, reference_input_i;
  logic serial_clock_i, serial_input_line_i, latch_strobe_i;
  logic if_pfd_ref_tick_o, if_counter_reset_o, if_charge_pump_tristate_o;
  logic if_powerdown_o, if_lock_detect_reset_o, if_pd_polarity_o;
  logic [2:0] if_charge_pump_current_o;
  logic [1:0] if_test_mode_o;
  logic if_side_awake_o, rf_side_awake_o;
  logic resync_enable_o, resync_pending_o, resync_fire_o;
  int failures, n_tests, ticks, fires;

  sicr_top dut_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .serial_clock_i(serial_clock_i),
    .serial_input_line_i(serial_input_line_i),
    .latch_strobe_i(latch_strobe_i),
    .reference_input_i(reference_input_i),
    .if_pfd_ref_tick_o(if_pfd_ref_tick_o),
    .if_counter_reset_o(if_counter_reset_o),
    .if_charge_pump_tristate_o(if_charge_pump_tristate_o),
    .if_powerdown_o(if_powerdown_o),
    .if_lock_detect_reset_o(if_lock_detect_reset_o),
    .if_pd_polarity_o(if_pd_polarity_o),
    .if_charge_pump_current_o(if_charge_pump_current_o),
    .if_test_mode_o(if_test_mode_o),
    .if_side_awake_o(if_side_awake_o),
    .rf_side_awake_o(rf_side_awake_o),
    .resync_enable_o(resync_enable_o),
    .resync_pending_o(resync_pending_o),
    .resync_fire_o(resync_fire_o)
  );
  sicr_host host_u (.clk_i(clk_i), .sclk_o(serial_clock_i),
    .serial_input_line_o(serial_input_line_i), .latch_o(latch_strobe_i));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Pulse counters, cleared by scenarios
  always @(posedge clk_i)
  begin
    if (if_pfd_ref_tick_o === 1'b1) ticks <= ticks + 1;
    if (resync_fire_o === 1'b1) fires <= fires + 1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask : hold

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [23:0] w);
    host_u.send_word(w, 4);
  endtask : wr

  // Reference levels of 4 clocks clear the pin filter
  task automatic refp(input int n);
    repeat (n)
    begin
      reference_input_i = 1'b1;
      hold(4);
      reference_input_i = 1'b0;
      hold(4);
    end
    hold(4);
  endtask : refp

  task automatic t_bringup();
    chk({if_powerdown_o, if_counter_reset_o, if_side_awake_o}, 3'h6);
    wr(24'h000586);
    chk({if_pd_polarity_o, if_charge_pump_current_o, if_test_mode_o}, 6'h34);
    wr(24'h00001d);
    wr(24'h000004);
    chk(if_powerdown_o, 1'b1);
    wr(24'h000003);
    chk({if_side_awake_o, if_powerdown_o, if_charge_pump_tristate_o}, 3'h4);
    chk(if_lock_detect_reset_o, 1'b0);
    chk(rf_side_awake_o, 1'b0);
    wr(24'h000002);
    wr(24'h000001);
    wr(24'h000000);
    chk({rf_side_awake_o, resync_pending_o}, 2'h2);
  endtask : t_bringup

  task automatic t_divider();
    ticks = 0;
    refp(6);
    chk(ticks, 2);
    wr(24'h04001d);
    ticks = 0;
    refp(6);
    chk(ticks, 4);
    wr(24'h00001d);
  endtask : t_divider

  task automatic t_ctrl();
    wr(24'h00058e);
    ticks = 0;
    refp(3);
    chk({if_counter_reset_o, 8'(ticks)}, 9'h100);
    wr(24'h000596);
    chk({if_charge_pump_tristate_o, if_counter_reset_o}, 2'h2);
    wr(24'h0005a6);
    chk({if_powerdown_o, if_counter_reset_o, if_charge_pump_tristate_o}, 3'h7);
    chk(if_lock_detect_reset_o, 1'b1);
    wr(24'h000526);
    chk({if_powerdown_o, if_pd_polarity_o}, 2'h2);
    wr(24'h000506);
    ticks = 0;
    refp(6);
    chk({if_powerdown_o, if_charge_pump_current_o, 8'(ticks)}, 12'h502);
  endtask : t_ctrl

  task automatic t_resync();
    wr(24'h000015);
    wr(24'h00c586);
    chk(resync_enable_o, 1'b0);
    wr(24'h00c986);
    chk(resync_enable_o, 1'b1);
    fires = 0;
    wr(24'h000000);
    chk(resync_pending_o, 1'b1);
    refp(1);
    host_u.send_word(24'h000001, 7);
    refp(1);
    chk({resync_pending_o, 8'(fires)}, 9'h100);
    refp(1);
    chk({resync_pending_o, 8'(fires)}, 9'h001);
    wr(24'h000586);
    chk(resync_enable_o, 1'b0);
    // Address 7 must be ignored although its body would set every control bit
    wr(24'h00ffff);
    chk({resync_enable_o, if_powerdown_o, if_pd_polarity_o, if_test_mode_o}, 5'h04);
  endtask : t_resync

  // Mid-run reset, then RF-only bring-up; IF N and IF control stay unwritten
  task automatic t_rfonly();
    rst_i = 1'b1;
    hold(3);
    rst_i = 1'b0;
    hold(2);
    chk({if_side_awake_o, rf_side_awake_o, if_powerdown_o, resync_enable_o}, 4'h2);
    wr(24'h000003);
    wr(24'h000002);
    wr(24'h000001);
    wr(24'h000000);
    ticks = 0;
    refp(3);
    chk({rf_side_awake_o, if_side_awake_o, if_powerdown_o, 8'(ticks)}, 11'h500);
  endtask : t_rfonly

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    reference_input_i = 1'b0;
    failures = 0;
    n_tests = 0;
    hold(3);
    rst_i = 1'b0;
    hold(2);
    t_bringup();
    t_divider();
    t_ctrl();
    t_resync();
    t_rfonly();
    results();
  end

  // Watchdog, well past the roughly 5800 clocks needed
  initial
  begin
    repeat (30000) @(posedge clk_i);
    failures++;
    results();
  end
endmodule : tb_synth_if_control_resync
`default_nettype wire
